// File: serial_port_pkg.sv
package serial_port_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] IDX_DATA = 8'h60;
  localparam logic [7:0] IDX_CTRL = 8'h61;
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
  localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};

  // Control register field positions.
  localparam int CTRL_DONE = 7;
  localparam int CTRL_FULL = 6;
  localparam int CTRL_MODE_HI = 5;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_IDLE_LVL = 3;
  localparam int CTRL_PHASE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;

  // Reset values.
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Function field encodings.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // Master bit rates in bit/s and clock timing.
  localparam int CLK_HZ = 25_000_000;
  localparam int RATE0_BPS = 2_000_000;
  localparam int RATE1_BPS = 1_000_000;
  localparam int RATE2_BPS = 500_000;
  localparam int RATE3_BPS = 62_500;
  localparam int FAST_ACTIVE_DIV = 3;
  localparam int SLOW_ACTIVE_DIV = 2;
  localparam int BITS_PER_BYTE = 8;
  localparam int CNT_W = 16;

  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} shift_state_t;

  // Synchronised view of the serial pins.
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic sel_n;
  } pin_in_t;

  // Pin drive; each oe is high while the block drives the pin.
  typedef struct packed {
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic sck_o;
    logic sck_oe;
  } pin_out_t;

  // Bypass enables taken from the general purpose data bits.
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
  } bypass_t;

  typedef struct packed {
    pin_in_t pin_s1;
    pin_in_t pin_s2;
    pin_in_t pin_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic [7:0] shreg;
    logic full;
    logic done;
    logic [1:0] mode;
    logic idle_lvl;
    logic phase;
    logic [1:0] rate;
    shift_state_t state;
    logic [2:0] bitcnt;
    logic [CNT_W-1:0] cnt;
    logic sck_act;
    logic out_bit;
    pin_out_t pins;
    logic irq;
    logic wake;
  } state_t;

endpackage : serial_port_pkg

// File: byte_serial_port.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module byte_serial_port #(
  parameter int CLK_HZ = serial_port_pkg::CLK_HZ
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave.
  input wire logic [serial_port_pkg::APB_AW-1:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial pins and their bypass enables.
  input wire serial_port_pkg::pin_in_t i_pins,
  input wire serial_port_pkg::bypass_t i_bypass,
  output serial_port_pkg::pin_out_t o_pins,
  // Interrupt and wake.
  input wire logic i_irq_en,
  output logic o_port_irq,
  output logic o_wake
);

  // Bit periods in system clocks for each master rate.
  localparam int BIT0 = CLK_HZ / serial_port_pkg::RATE0_BPS;
  localparam int BIT1 = CLK_HZ / serial_port_pkg::RATE1_BPS;
  localparam int BIT2 = CLK_HZ / serial_port_pkg::RATE2_BPS;
  localparam int BIT3 = CLK_HZ / serial_port_pkg::RATE3_BPS;
  localparam int ACT0 = BIT0 / serial_port_pkg::FAST_ACTIVE_DIV;
  localparam int IDL0 = BIT0 - ACT0;
  localparam int ACT1 = BIT1 / serial_port_pkg::SLOW_ACTIVE_DIV;
  localparam int ACT2 = BIT2 / serial_port_pkg::SLOW_ACTIVE_DIV;
  localparam int ACT3 = BIT3 / serial_port_pkg::SLOW_ACTIVE_DIV;

  // Refuse clock rates that cannot form the fastest pulse or the counter.
  if (ACT0 < 1 || IDL0 < 1) begin : g_clk_too_slow
    $error("Clock too slow for fastest serial rate.");
  end
  if (ACT3 >= (1 << serial_port_pkg::CNT_W)) begin : g_clk_too_fast
    $error("Clock too fast for the half-period counter.");
  end

  // Half-period lengths minus one; fast rate is one third active.
  function automatic logic [serial_port_pkg::CNT_W-1:0] half_len(
      input logic [1:0] rate, input logic active);
    logic [serial_port_pkg::CNT_W-1:0] len;
    len = '0;
    unique case (rate)
      2'h0: len = active ? serial_port_pkg::CNT_W'(ACT0 - 1)
                         : serial_port_pkg::CNT_W'(IDL0 - 1);
      2'h1: len = serial_port_pkg::CNT_W'(ACT1 - 1);
      2'h2: len = serial_port_pkg::CNT_W'(ACT2 - 1);
      2'h3: len = serial_port_pkg::CNT_W'(ACT3 - 1);
    endcase
    return len;
  endfunction : half_len

  serial_port_pkg::state_t s;
  serial_port_pkg::state_t next_s;

  logic acc;
  logic hit_data;
  logic hit_ctrl;
  logic wr;
  logic master;
  logic slave;
  logic sel_low;
  logic sel_fall;
  logic sel_rise;
  logic lead;
  logic trail;
  logic e1;
  logic e2;
  logic in_bit;
  logic drive_edge;
  logic samp_edge;
  logic byte_done;
  logic load;
  logic [7:0] sh_in;

  // Outputs come straight from the state register.
  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_pins = s.pins;
  assign o_port_irq = s.irq;
  assign o_wake = s.wake;

  // Next-state logic for bus, registers, shifter and pins.
  always_comb begin
    next_s = s;
    e1 = 1'b0;
    e2 = 1'b0;
    byte_done = 1'b0;
    load = 1'b0;
    // Two-stage pin synchroniser plus a history stage for edge finding.
    next_s.pin_s1 = i_pins;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.irq = 1'b0;
    next_s.wake = 1'b0;

    // APB: one wait state, read data and error registered on the same edge as pready.
    acc = i_psel & i_penable;
    hit_data = (i_paddr == serial_port_pkg::ADDR_DATA);
    hit_ctrl = (i_paddr == serial_port_pkg::ADDR_CTRL);
    next_s.pready = acc & ~s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h0;
    if (acc & ~s.pready) begin
      next_s.pslverr = ~(hit_data | hit_ctrl);
      if (hit_data) begin
        next_s.prdata = {24'h0, s.rxbuf};
      end else if (hit_ctrl) begin
        next_s.prdata = {24'h0, s.done, s.full, s.mode, s.idle_lvl,
                         s.phase, s.rate};
      end
    end
    wr = acc & s.pready & i_pwrite & ~s.pslverr;

    // Control write; done flag only clears on a written zero.
    if (wr & hit_ctrl) begin
      next_s.mode = i_pwdata[serial_port_pkg::CTRL_MODE_HI:
                             serial_port_pkg::CTRL_MODE_LO];
      next_s.idle_lvl = i_pwdata[serial_port_pkg::CTRL_IDLE_LVL];
      next_s.phase = i_pwdata[serial_port_pkg::CTRL_PHASE];
      next_s.rate = i_pwdata[serial_port_pkg::CTRL_RATE_HI:
                             serial_port_pkg::CTRL_RATE_LO];
      if (!i_pwdata[serial_port_pkg::CTRL_DONE]) begin
        next_s.done = 1'b0;
      end
    end

    // Mode decode; the reserved code falls into the disabled path.
    master = (s.mode == serial_port_pkg::MODE_MASTER);
    slave = (s.mode == serial_port_pkg::MODE_SLAVE);
    sel_low = ~s.pin_s2.sel_n;
    sel_fall = s.pin_prev.sel_n & ~s.pin_s2.sel_n;
    sel_rise = ~s.pin_prev.sel_n & s.pin_s2.sel_n;
    lead = (s.pin_prev.sck == s.idle_lvl) & (s.pin_s2.sck != s.idle_lvl);
    trail = (s.pin_prev.sck != s.idle_lvl) & (s.pin_s2.sck == s.idle_lvl);
    in_bit = master ? s.pin_s2.miso : s.pin_s2.mosi;

    // Edge sources: own timer as master, external clock as slave.
    if (master && s.state == serial_port_pkg::ST_SHIFT) begin
      if (s.cnt == '0) begin
        if (!s.sck_act) begin
          e1 = 1'b1;
          next_s.sck_act = 1'b1;
          next_s.cnt = half_len(s.rate, 1'b1);
        end else begin
          e2 = 1'b1;
          next_s.sck_act = 1'b0;
          next_s.cnt = half_len(s.rate, 1'b0);
          if (s.bitcnt == 3'(serial_port_pkg::BITS_PER_BYTE - 1)) begin
            byte_done = 1'b1;
          end
          next_s.bitcnt = s.bitcnt + 3'h1;
        end
      end else begin
        next_s.cnt = s.cnt - serial_port_pkg::CNT_W'(1);
      end
    end else if (slave && s.state == serial_port_pkg::ST_SHIFT
                 && sel_low && !sel_fall) begin
      e1 = lead;
      e2 = trail;
    end

    // Phase zero samples on the first edge, phase one on the second.
    drive_edge = s.phase ? e1 : e2;
    samp_edge = s.phase ? e2 : e1;
    sh_in = {s.shreg[6:0], in_bit};
    if (samp_edge) begin
      next_s.shreg = sh_in;
      if (slave) begin
        if (s.bitcnt == 3'(serial_port_pkg::BITS_PER_BYTE - 1)) begin
          byte_done = 1'b1;
        end
        next_s.bitcnt = s.bitcnt + 3'h1;
      end
    end
    if (drive_edge) begin
      next_s.out_bit = s.shreg[7];
    end

    // Completed byte: receive buffer, done flag and interrupt together.
    if (byte_done) begin
      // With the last sample on this same edge the shifter is one bit short.
      next_s.rxbuf = samp_edge ? sh_in : s.shreg;
      next_s.done = 1'b1;
      next_s.irq = 1'b1;
      next_s.wake = slave & i_irq_en;
      next_s.state = (master || !sel_low) ? serial_port_pkg::ST_IDLE
                                          : serial_port_pkg::ST_SHIFT;
    end

    // Transmit buffer to shift register moves.
    if (master) begin
      load = s.full & (s.state == serial_port_pkg::ST_IDLE
                       || byte_done);
    end else if (slave) begin
      if (sel_rise) begin
        next_s.state = serial_port_pkg::ST_IDLE;
        next_s.bitcnt = 3'h0;
        next_s.irq = byte_done;
        next_s.wake = byte_done & i_irq_en;
      end else if (sel_fall) begin
        load = 1'b1;
      end else begin
        load = s.full & sel_low & (s.state == serial_port_pkg::ST_IDLE
                                   || byte_done);
      end
    end else begin
      next_s.state = serial_port_pkg::ST_IDLE;
      next_s.sck_act = 1'b0;
      next_s.bitcnt = 3'h0;
    end
    if (load) begin
      next_s.shreg = s.txbuf;
      next_s.out_bit = s.txbuf[7];
      next_s.full = 1'b0;
      next_s.bitcnt = 3'h0;
      next_s.state = serial_port_pkg::ST_SHIFT;
      next_s.sck_act = 1'b0;
      next_s.cnt = half_len(s.rate, 1'b0);
    end

    // Data write after the load so a byte written in the load cycle is not lost.
    if (wr & hit_data) begin
      next_s.txbuf = i_pwdata[7:0];
      next_s.full = 1'b1;
    end

    // Pin drive; select is never driven, it stays a firmware pin.
    next_s.pins = '0;
    if (master) begin
      next_s.pins.mosi_o = next_s.out_bit;
      next_s.pins.mosi_oe = i_bypass.mosi;
      next_s.pins.sck_o = s.idle_lvl ^ next_s.sck_act;
      next_s.pins.sck_oe = i_bypass.sck;
    end else if (slave) begin
      next_s.pins.miso_o = next_s.out_bit;
      next_s.pins.miso_oe = i_bypass.miso & sel_low;
    end
  end

  // Single state register with synchronous active-low reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= '0;
      s.pin_s1 <= '1;
      s.pin_s2 <= '1;
      s.pin_prev <= '1;
      s.txbuf <= serial_port_pkg::DATA_RST;
      s.rxbuf <= serial_port_pkg::DATA_RST;
      s.mode <= serial_port_pkg::CTRL_RST[serial_port_pkg::CTRL_MODE_HI:
                                          serial_port_pkg::CTRL_MODE_LO];
      s.state <= serial_port_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

endmodule : byte_serial_port

// File: serial_port_properties.sv
`timescale 1ns/1ps
// Port-level checks of the serial port block.
module serial_port_properties (
  // Clock, reset and bus.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [serial_port_pkg::APB_AW-1:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pins and events.
  input wire serial_port_pkg::pin_in_t i_pins,
  input wire serial_port_pkg::bypass_t i_bypass,
  input wire serial_port_pkg::pin_out_t o_pins,
  input wire logic o_port_irq,
  input wire logic o_wake
);
  logic [4:0] tog;
  logic [4:0] tog_now;
  logic last_sck;
  logic last_oe;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Toggles of the driven clock pin since the last byte ended.
  assign tog_now = tog + 5'(last_oe && o_pins.sck_oe &&
    o_pins.sck_o != last_sck);
  // Toggle counter; it restarts at each byte and when the pin is released.
  always_ff @(posedge i_clk) begin
    last_sck <= o_pins.sck_o;
    last_oe <= o_pins.sck_oe;
    if (!i_rst_n || !o_pins.sck_oe || o_port_irq) begin
      tog <= 5'h0;
    end else begin
      tog <= tog_now;
    end
  end
  sequence s_setup;
    i_psel && !i_penable ##1 i_psel && i_penable;
  endsequence
  property p_ready_wait;
    s_setup |-> !o_pready ##1 o_pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("ready not in second access cycle");
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_map;
    o_pready |-> o_pslverr == !(i_paddr == serial_port_pkg::ADDR_DATA ||
      i_paddr == serial_port_pkg::ADDR_CTRL);
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("error response wrong for address");
  property p_irq_pulse; o_port_irq |=> !o_port_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  property p_eight; o_port_irq && o_pins.sck_oe |-> tog_now == 5'h10;
  endproperty
  a_eight: assert property (p_eight)
    else $error("byte without eight clock pulses");
  property p_sck_byp; o_pins.sck_oe |-> $past(i_bypass.sck); endproperty
  a_sck_byp: assert property (p_sck_byp)
    else $error("clock pin driven without bypass");
  property p_miso_sel;
    $rose(o_pins.miso_oe) |-> !$past(i_pins.sel_n, 3) && $past(i_bypass.miso);
  endproperty
  a_miso_sel: assert property (p_miso_sel)
    else $error("slave output driven without select");
  property p_wake; o_wake |-> o_port_irq; endproperty
  a_wake: assert property (p_wake)
    else $error("wake without end of byte");
endmodule : serial_port_properties

bind byte_serial_port serial_port_properties serial_port_properties_inst (
  .i_clk, .i_rst_n, .i_paddr, .i_psel, .i_penable, .o_pready, .o_pslverr,
  .i_pins, .i_bypass, .o_pins, .o_port_irq, .o_wake);

// File: far_slave_model.sv
`timescale 1ns/1ps
// Far serial slave; it counts up from its load byte after every byte.
module far_slave_model (
  // Link and settings.
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_idle_lvl,
  input wire logic i_phase,
  input wire logic i_load,
  input wire logic [7:0] i_tx,
  // Outputs.
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic [7:0] sh;
  logic [7:0] val;
  int n;
  // Load primes the first bit early when sampling on the first edge.
  always @(posedge i_load) begin
    val = i_tx;
    sh = val;
    n = 0;
    if (!i_phase) begin
      o_miso = sh[7];
      sh = sh << 1;
    end
  end
  // Samples and shifts MSB first on the edges that phase selects.
  always @(i_sck) begin
    if ((i_sck != i_idle_lvl) ^ i_phase) begin
      o_rx = {o_rx[6:0], i_mosi};
      n++;
      if (n == 8) begin
        n = 0;
        val = val + 8'h01;
        sh = val;
      end
    end else begin
      o_miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule : far_slave_model

// File: byte_serial_port_master_slave_bench.sv
`timescale 1ns/1ps
// Exercises the serial port over APB and its serial pins.
module byte_serial_port_master_slave_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic b_sck, b_mosi, sel_n, irq_en, load, clock_idle_level, clock_sample_phase, irq, wake, pmiso;
  logic sck_w, mosi_w, miso_w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ptx, prx, d, s, g;
  serial_port_pkg::bypass_t byp;
  serial_port_pkg::pin_out_t op;
  int num_errors = 0, tests_run = 0, act, pul, nirq = 0, nwk = 0, base;
  localparam logic [11:0] DA = serial_port_pkg::ADDR_DATA;
  localparam logic [11:0] CA = serial_port_pkg::ADDR_CTRL;
  // Wire levels from every driver's enable.
  assign sck_w = op.sck_oe ? op.sck_o : b_sck;
  assign mosi_w = op.mosi_oe ? op.mosi_o : b_mosi;
  assign miso_w = op.miso_oe ? op.miso_o : pmiso;
  byte_serial_port byte_serial_port_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_paddr(paddr), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pins({sck_w, mosi_w, miso_w, sel_n}),
    .i_bypass(byp), .o_pins(op), .i_irq_en(irq_en), .o_port_irq(irq),
    .o_wake(wake));
  far_slave_model far_slave_model_inst (.i_sck(sck_w), .i_mosi(mosi_w),
    .i_idle_lvl(clock_idle_level), .i_phase(clock_sample_phase), .i_load(load), .i_tx(ptx),
    .o_miso(pmiso), .o_rx(prx));
  // System clock.
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Event counters.
  always @(posedge clk) begin
    if (irq === 1'b1) nirq++;
    if (wake === 1'b1) nwk++;
  end
  function automatic int act_of(input logic [1:0] r);
    return r == 2'h0 ? 4 : r == 2'h1 ? 12 : r == 2'h2 ? 25 : 200;
  endfunction : act_of
  function automatic logic [7:0] ctl(input logic [1:0] m, logic [1:0] r);
    return {2'h0, m, clock_idle_level, clock_sample_phase, r};
  endfunction : ctl
  task automatic chk(input string nm, input logic [31:0] sn, x);
    tests_run++;
    if (sn !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, sn);
    end
  endtask : chk
  task automatic apb(input logic w, logic [11:0] a, logic [7:0] v);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    penable <= 0;
    @(posedge clk);
    penable <= 1;
    k = 0;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) num_errors++;
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wait_irq(input int b, lim);
    int k;
    logic was;
    act = 0;
    pul = 0;
    was = 1'b0;
    for (k = 0; k < lim && nirq == b; k++) begin
      @(posedge clk);
      if (op.sck_o !== clock_idle_level && !was) pul++;
      was = (op.sck_o !== clock_idle_level);
      if (was) act++;
    end
  endtask : wait_irq
  task automatic bits(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      b_mosi = m[7-i];
      #160 b_sck = 1;
      g[7-i] = miso_w;
      #160 b_sck = 0;
    end
  endtask : bits
  task automatic complete_run();
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // Watchdog.
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
  // Test sequence.
  initial begin
    {rst_n, psel, penable, pwrite, b_sck, b_mosi, irq_en, load} = 0;
    {clock_idle_level, clock_sample_phase, paddr, pwdata, byp} = 0;
    sel_n = 1;
    g = 0;
    ptx = 0;
    void'($urandom(32'h2420));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    apb(0, DA, 0); chk("data reset", rd, 0);
    apb(0, CA, 0); chk("ctrl reset", rd, 0);
    apb(1, 12'h010, 8'h5a); chk("unmapped err", e, 1);
    apb(1, CA, 8'h40); apb(0, CA, 0); chk("full ro", rd, 0);
    $display("test 1 done");
    for (int r = 0; r < 4; r++) begin
      {clock_sample_phase, clock_idle_level} = 2'(r);
      byp <= 0;
      apb(1, CA, ctl(serial_port_pkg::MODE_MASTER, 2'(r)));
      byp <= 3'h7;
      // Let the clock pin settle at its idle level before priming the slave.
      repeat (2) @(posedge clk);
      ptx <= 8'($urandom);
      load <= 1;
      d = 8'($urandom);
      @(posedge clk);
      load <= 0;
      apb(1, DA, d);
      wait_irq(nirq, 20000);
      chk("active", act, 8 * act_of(2'(r)));
      chk("pulses", pul, 8);
      chk("sent", prx, d);
      apb(0, DA, 0); chk("received", rd, ptx);
      apb(0, CA, 0);
      chk("done", rd, ctl(serial_port_pkg::MODE_MASTER, 2'(r)) | 8'h80);
      apb(1, CA, ctl(serial_port_pkg::MODE_MASTER, 2'(r)));
      apb(0, CA, 0); chk("cleared", rd[7], 0);
    end
    $display("test 2 done");
    {clock_sample_phase, clock_idle_level} = 0;
    byp <= 0;
    apb(1, CA, ctl(serial_port_pkg::MODE_MASTER, 2'h0));
    byp <= 3'h7;
    load <= 1;
    @(posedge clk);
    load <= 0;
    s = 8'($urandom);
    apb(1, DA, 8'h11); apb(1, DA, 8'h22);
    apb(0, CA, 0); chk("full", rd[6], 1);
    apb(1, DA, s);
    wait_irq(nirq, 2000);
    wait_irq(nirq, 2000); chk("queued pulses", pul, 8);
    chk("replaced", prx, s);
    apb(0, DA, 0); chk("overwrite", rd, 8'(ptx + 8'h01));
    $display("test 3 done");
    byp <= 0;
    apb(1, CA, ctl(serial_port_pkg::MODE_SLAVE, 2'h3));
    byp <= 3'h7;
    irq_en <= 1;
    s = 8'($urandom);
    d = 8'($urandom);
    apb(1, DA, s);
    #7 sel_n = 0;
    #200 chk("miso drive", op.miso_oe, 1);
    base = nirq;
    bits(d, 8);
    wait_irq(base, 40);
    chk("slave irq", nirq, base + 1);
    chk("wake", nwk, 1);
    chk("slave out", g, s);
    apb(0, DA, 0); chk("slave in", rd, d);
    #7 bits(~d, 4);
    sel_n = 1;
    base = nirq;
    #800 chk("abort", nirq, base);
    chk("miso off", op.miso_oe, 0);
    sel_n = 0;
    #400 bits(d, 8);
    wait_irq(base, 40);
    chk("reload", g, s);
    sel_n = 1;
    $display("test 4 done");
    for (int m = 0; m < 4; m += 3) begin
      apb(1, CA, ctl(2'(m), 2'h0));
      base = nirq;
      apb(1, DA, 8'ha5);
      wait_irq(base, 300);
      chk("no transfer", nirq, base);
      chk("no clock", act, 0);
    end
    $display("test 5 done");
    complete_run();
  end
endmodule : byte_serial_port_master_slave_bench
